//--- sccr_map.svh
// sccr_map.svh: register indices, field codes, reset values and timing
// assumes register indices are word indices, byte address is index * 4
`ifndef SCCR_MAP_SVH
`define SCCR_MAP_SVH
`define SCCR_IDX_CMD 12'h860
`define SCCR_IDX_SCON0 12'h882
`define SCCR_IDX_SCM0 12'h884
`define SCCR_IDX_STEP 12'h010
`define SCCR_IDX_MASK 12'h8b2
`define SCCR_IDX_MODE 12'h8b4
`define SCCR_CMD_WMASK 8'hf7
`define SCCR_SCM_WMASK 16'hfdff
`define SCCR_RST16 16'h0000
`define SCCR_RST8 8'h00
`define SCCR_CH_RSVD 2'b11
`define SCCR_MODE_NONMULTIPLEXED_INTERFACE 2'b00
`define SCCR_MODE_PCM 2'b01
`define SCCR_MODE_IDL 2'b10
`define SCCR_MODE_GCI 2'b11
`define SCCR_ROUTE_CH1 2'b01
`define SCCR_ROUTE_CH2 2'b10
`define SCCR_ROUTE_CH3 2'b11
`define SCCR_OP_BCS 2'b11
`define SCCR_PROTO_BISYNC 2'b11
`define SCCR_PRE_LAST 2'h3
`define SCCR_CMD_TIME_NS 40
`define SCCR_CLK_NS 10
`define SCCR_CMD_CYC ((`SCCR_CMD_TIME_NS+`SCCR_CLK_NS-1)/`SCCR_CLK_NS)
`endif

//--- sccr_pkg.sv
// sccr_pkg.sv: register layouts, decoded config records, command states
// assumes the layouts match the 16-bit and 8-bit register images
package sccr_pkg;
   typedef struct packed {
      logic soft_reset;
      logic gci_select;
      logic [1:0] opcode;
      logic rsvd;
      logic [1:0] target_channel_field;
      logic command_semaphore_flag;
   } sccr_cmd_t;
   typedef struct packed {
      logic wired_or_select;
      logic external_clock_select;
      logic tx_clock_select;
      logic rx_clock_select;
      logic [10:0] baud_divider_field;
      logic prescale_bit;
   } sccr_channel_clock_config_t;
   typedef struct packed {
      logic [3:0] flag_count_field;
      logic crc_length_bit;
      logic flag_sharing_enable;
      logic rsvd;
      logic retransmit_enable;
      logic idle_flags_bit;
      logic line_encoding_bit;
      logic [1:0] diag_mode;
      logic receiver_enable_bit;
      logic transmitter_enable_bit;
      logic [1:0] chan_mode;
   } sccr_scm_t;
   typedef struct packed {
      logic force_low_bit;
      logic sync_shape_select;
      logic [1:0] si_diag_field;
      logic strobe_control_two;
      logic strobe_control_one;
      logic [1:0] b2_route_field;
      logic [1:0] b1_route_field;
      logic [1:0] d_route_field;
      logic chan3_mux_disconnect;
      logic chan2_mux_disconnect;
      logic [1:0] interface_mode_field;
   } sccr_serial_interface_mode_t;
   typedef struct packed {
      logic tx_on;
      logic rx_on;
      logic crc32;
      logic nrzi;
      logic idle_flags;
      logic retransmit;
      logic shared_flag;
      logic [3:0] min_flags;
      logic [1:0] diag;
      logic [1:0] proto;
   } sccr_chan_cfg_t;
   typedef struct packed {
      logic sync_shape;
      logic [1:0] si_diag;
      logic [1:0] if_mode;
      logic [2:0] mux_conn;
      logic [2:0] d_route;
      logic [2:0] b1_route;
      logic [2:0] b2_route;
   } sccr_si_cfg_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b100
   } sccr_state_t;
endpackage : sccr_pkg

//--- sccr_regs.sv
// sccr_regs.sv: serial channel config and command registers, APB slave
// assumes channel engines on CLK; TIMER_INPUT_ONE_PIN, TX_CLOCK_PIN, RCLK come from pins
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "sccr_map.svh"
module sccr_regs
   import sccr_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic TIMER_INPUT_ONE_PIN,
   input wire logic [2:0] TX_CLOCK_PIN,
   input wire logic [2:0] RCLK,
   input wire logic L1_TXD_IN,
   output logic L1_TXD,
   input wire logic [2:0] CH_TXD,
   output logic [2:0] TXD_O,
   output logic [2:0] TXD_OE,
   input wire logic B1_SLOT,
   input wire logic B2_SLOT,
   input wire logic [2:0] SLOT_BIT,
   output logic DS1,
   output logic DS2,
   output logic SLOT_BIT_EN,
   output logic [2:0] TX_CLK_EN,
   output logic [2:0] RX_CLK_EN,
   output logic CMD_VALID,
   output logic [3:0] CMD_OP,
   output logic [2:0] CMD_CHAN,
   output logic CMD_GCI,
   output sccr_chan_cfg_t [2:0] CHAN_CFG,
   output sccr_si_cfg_t SI_CFG
);
   sccr_cmd_t cmd_q, cmd_d;
   sccr_channel_clock_config_t [2:0] channel_clock_config_q, channel_clock_config_d;
   sccr_scm_t [2:0] scm_q, scm_d;
   sccr_serial_interface_mode_t mode_q, mode_d;
   logic [15:0] mask_q, mask_d;
   sccr_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic rdy_q, rdy_d;
   logic err_q, err_d;
   logic [31:0] rd_q, rd_d;
   logic [11:0] idx;
   logic acc, wr, hit, fire, wr_cmd;
   logic [15:0] rv;

   assign idx = PADDR[13:2];
   assign acc = PSEL && PENABLE && rdy_q;
   assign wr = acc && PWRITE && hit;
   assign wr_cmd = wr && idx == `SCCR_IDX_CMD;
   assign fire = st_q == ST_DONE;

   always_comb begin
      cmd_d = cmd_q;
      channel_clock_config_d = channel_clock_config_q;
      scm_d = scm_q;
      mode_d = mode_q;
      mask_d = mask_q;
      st_d = st_q;
      cnt_d = cnt_q;
      hit = 1'b0;
      rv = `SCCR_RST16;
      if (PADDR[15:14] == 2'h0 && PADDR[1:0] == 2'h0) begin
         if (idx == `SCCR_IDX_CMD) begin
            hit = 1'b1;
            rv = {8'h00, cmd_q};
         end
         if (idx == `SCCR_IDX_MASK) begin
            hit = 1'b1;
            rv = mask_q;
         end
         if (idx == `SCCR_IDX_MODE) begin
            hit = 1'b1;
            rv = mode_q;
         end
         for (int n = 0; n < 3; n++) begin
            if (idx == `SCCR_IDX_SCON0 + 12'(n) * `SCCR_IDX_STEP) begin
               hit = 1'b1;
               rv = channel_clock_config_q[n];
               if (wr) begin
                  channel_clock_config_d[n] = PWDATA[15:0];
               end
            end
            if (idx == `SCCR_IDX_SCM0 + 12'(n) * `SCCR_IDX_STEP) begin
               hit = 1'b1;
               rv = scm_q[n];
               if (wr) begin
                  scm_d[n] = PWDATA[15:0] & `SCCR_SCM_WMASK;
               end
            end
         end
      end
      if (wr && idx == `SCCR_IDX_MASK) begin
         mask_d = PWDATA[15:0];
      end
      if (wr && idx == `SCCR_IDX_MODE) begin
         mode_d = PWDATA[15:0];
      end
      // command walk; flag held for the whole run, freed at the end
      case (st_q)
         ST_IDLE: begin
            if (cmd_q.command_semaphore_flag) begin
               st_d = ST_EXEC;
               cnt_d = 4'(`SCCR_CMD_CYC - 1);
            end
         end
         ST_EXEC: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
               st_d = ST_DONE;
            end
         end
         ST_DONE: begin
            st_d = ST_IDLE;
            cmd_d.command_semaphore_flag = 1'b0;
            cmd_d.soft_reset = 1'b0;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      // a fresh write wins over the completion clear
      if (wr_cmd) begin
         cmd_d = PWDATA[7:0] & `SCCR_CMD_WMASK;
      end
      rdy_d = PSEL && PENABLE && !rdy_q;
      err_d = rdy_d && !hit;
      rd_d = (rdy_d && !PWRITE) ? {16'h0000, rv} : 32'h0000_0000;
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         cmd_q <= `SCCR_RST8;
         channel_clock_config_q <= {3{`SCCR_RST16}};
         scm_q <= {3{`SCCR_RST16}};
         mode_q <= `SCCR_RST16;
         mask_q <= `SCCR_RST16;
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         rd_q <= 32'h0000_0000;
      end else begin
         cmd_q <= cmd_d;
         channel_clock_config_q <= channel_clock_config_d;
         scm_q <= scm_d;
         mode_q <= mode_d;
         mask_q <= mask_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
         rd_q <= rd_d;
      end
   end
   assign PREADY = rdy_q;
   assign PSLVERR = err_q;
   assign PRDATA = rd_q;

   // pin sync: a change counts once stages two and three agree
   logic [6:0] s1_q, s2_q, s3_q, f_q, f_d, rise;
   always_comb begin
      f_d = (s2_q & s3_q) | (f_q & (s2_q | s3_q));
      rise = f_d & ~f_q;
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         s1_q <= 7'h00;
         s2_q <= 7'h00;
         s3_q <= 7'h00;
         f_q <= 7'h00;
      end else begin
         s1_q <= {RCLK, TX_CLOCK_PIN, TIMER_INPUT_ONE_PIN};
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q <= f_d;
      end
   end

   // baud generator per channel; one-cycle ticks, no second clock
   logic [2:0] tick;
   for (genvar g = 0; g < 3; g++) begin : g_baud
      logic [1:0] pre_q, pre_d;
      logic [10:0] div_q, div_d;
      logic tick_q, tick_d, src, ptk;
      always_comb begin
         src = channel_clock_config_q[g].external_clock_select ? rise[0] : 1'b1;
         ptk = src && (!channel_clock_config_q[g].prescale_bit ||
                       pre_q == `SCCR_PRE_LAST);
         pre_d = src ? pre_q + 2'h1 : pre_q;
         div_d = div_q;
         tick_d = 1'b0;
         if (ptk) begin
            if (div_q == 11'h000) begin
               div_d = channel_clock_config_q[g].baud_divider_field;
               tick_d = 1'b1;
            end else begin
               div_d = div_q - 11'h001;
            end
         end
      end
      always_ff @(posedge CLK) begin
         if (SRST) begin
            pre_q <= 2'h0;
            div_q <= 11'h000;
            tick_q <= 1'b0;
         end else begin
            pre_q <= pre_d;
            div_q <= div_d;
            tick_q <= tick_d;
         end
      end
      assign tick[g] = tick_q;
   end

   function automatic logic [2:0] route(input logic [1:0] f,
                                        input sccr_serial_interface_mode_t m);
      logic [2:0] r;
      r = 3'h0;
      case (f)
         `SCCR_ROUTE_CH1: r = 3'h1;
         `SCCR_ROUTE_CH2: r = {1'b0, !m.chan2_mux_disconnect, 1'b0};
         `SCCR_ROUTE_CH3: r = {!m.chan3_mux_disconnect, 2'h0};
         default: r = 3'h0;
      endcase
      return r;
   endfunction : route

   // output group: every port below leaves from a flip-flop
   logic l1_q, l1_d, ds1_q, ds1_d, ds2_q, ds2_d, ben_q, ben_d;
   logic [2:0] txo_q, txo_d, txoe_q, txoe_d;
   logic [2:0] tce_q, tce_d, rce_q, rce_d;
   logic cv_q, cv_d, cg_q, cg_d;
   logic [3:0] cop_q, cop_d;
   logic [2:0] cch_q, cch_d;
   sccr_chan_cfg_t [2:0] cfg_q, cfg_d;
   sccr_si_cfg_t si_q, si_d;
   logic gci_md, b_md;

   always_comb begin
      gci_md = mode_q.interface_mode_field == `SCCR_MODE_GCI;
      b_md = gci_md || mode_q.interface_mode_field == `SCCR_MODE_IDL;
      l1_d = L1_TXD_IN && !(mode_q.force_low_bit && gci_md);
      ds1_d = (B1_SLOT && !mode_q.strobe_control_one) ||
              (B2_SLOT && mode_q.strobe_control_two);
      ds2_d = (B2_SLOT && !mode_q.strobe_control_two) ||
              (B1_SLOT && mode_q.strobe_control_one);
      ben_d = b_md && ((B1_SLOT && mask_q[{1'b0, SLOT_BIT}]) ||
              (B2_SLOT && mask_q[{1'b1, SLOT_BIT}]));
      for (int n = 0; n < 3; n++) begin
         // open drain only pulls low, never drives a one
         txo_d[n] = !channel_clock_config_q[n].wired_or_select && CH_TXD[n];
         txoe_d[n] = !channel_clock_config_q[n].wired_or_select || !CH_TXD[n];
         tce_d[n] = channel_clock_config_q[n].tx_clock_select ? rise[1 + n] :
                    tick[n];
         rce_d[n] = channel_clock_config_q[n].rx_clock_select ? rise[4 + n] :
                    tick[n];
         cfg_d[n].tx_on = scm_q[n].transmitter_enable_bit;
         cfg_d[n].rx_on = scm_q[n].receiver_enable_bit;
         cfg_d[n].crc32 = scm_q[n].crc_length_bit;
         cfg_d[n].nrzi = scm_q[n].line_encoding_bit;
         cfg_d[n].idle_flags = scm_q[n].idle_flags_bit;
         cfg_d[n].retransmit = scm_q[n].retransmit_enable;
         cfg_d[n].shared_flag = scm_q[n].flag_sharing_enable &&
            scm_q[n].flag_count_field == 4'h0;
         cfg_d[n].min_flags = scm_q[n].flag_count_field;
         if (scm_q[n].flag_sharing_enable &&
             scm_q[n].flag_count_field != 4'h0) begin
            cfg_d[n].min_flags = scm_q[n].flag_count_field - 4'h1;
         end
         cfg_d[n].diag = scm_q[n].diag_mode;
         cfg_d[n].proto = scm_q[n].chan_mode;
      end
      si_d.sync_shape = mode_q.sync_shape_select;
      si_d.si_diag = mode_q.si_diag_field;
      si_d.if_mode = mode_q.interface_mode_field;
      si_d.mux_conn = 3'h0;
      if (mode_q.interface_mode_field != `SCCR_MODE_NONMULTIPLEXED_INTERFACE) begin
         si_d.mux_conn = {!mode_q.chan3_mux_disconnect,
                          !mode_q.chan2_mux_disconnect, 1'b1};
      end
      si_d.d_route = route(mode_q.d_route_field, mode_q);
      si_d.b1_route = route(mode_q.b1_route_field, mode_q);
      si_d.b2_route = route(mode_q.b2_route_field, mode_q);
      // command issue; reserved channel is dropped unless gci
      cg_d = fire && cmd_q.gci_select;
      cv_d = fire && (cmd_q.gci_select ||
             cmd_q.target_channel_field != `SCCR_CH_RSVD);
      cch_d = 3'h0;
      if (!cmd_q.gci_select) begin
         cch_d = 3'h1 << cmd_q.target_channel_field;
      end
      cop_d = 4'h0;
      if (cv_d) begin
         cop_d = 4'h1 << cmd_q.opcode;
      end
      // block check reset means nothing outside bisync
      if (!cmd_q.gci_select && cmd_q.opcode == `SCCR_OP_BCS &&
          (cmd_q.target_channel_field == `SCCR_CH_RSVD ||
           scm_q[cmd_q.target_channel_field].chan_mode !=
           `SCCR_PROTO_BISYNC)) begin
         cop_d = 4'h0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         l1_q <= 1'b1;
         ds1_q <= 1'b0;
         ds2_q <= 1'b0;
         ben_q <= 1'b0;
         txo_q <= 3'h7;
         txoe_q <= 3'h7;
         tce_q <= 3'h0;
         rce_q <= 3'h0;
         cv_q <= 1'b0;
         cg_q <= 1'b0;
         cop_q <= 4'h0;
         cch_q <= 3'h0;
         cfg_q <= '0;
         si_q <= '0;
      end else begin
         l1_q <= l1_d;
         ds1_q <= ds1_d;
         ds2_q <= ds2_d;
         ben_q <= ben_d;
         txo_q <= txo_d;
         txoe_q <= txoe_d;
         tce_q <= tce_d;
         rce_q <= rce_d;
         cv_q <= cv_d;
         cg_q <= cg_d;
         cop_q <= cop_d;
         cch_q <= cch_d;
         cfg_q <= cfg_d;
         si_q <= si_d;
      end
   end
   assign L1_TXD = l1_q;
   assign DS1 = ds1_q;
   assign DS2 = ds2_q;
   assign SLOT_BIT_EN = ben_q;
   assign TXD_O = txo_q;
   assign TXD_OE = txoe_q;
   assign TX_CLK_EN = tce_q;
   assign RX_CLK_EN = rce_q;
   assign CMD_VALID = cv_q;
   assign CMD_GCI = cg_q;
   assign CMD_OP = cop_q;
   assign CMD_CHAN = cch_q;
   assign CHAN_CFG = cfg_q;
   assign SI_CFG = si_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence s_cmd_start;
      st_q == ST_IDLE && cmd_q.command_semaphore_flag;
   endsequence
   sequence s_cmd_end;
      st_q == ST_DONE ##1 (!cmd_q.command_semaphore_flag || $past(wr_cmd));
   endsequence
   a_flag_release: assert property (s_cmd_start |-> ##5 s_cmd_end)
      else $error("command flag not released on time");
   a_gci_issue: assert property (fire && cmd_q.gci_select |=>
      CMD_GCI && CMD_VALID && CMD_CHAN == 3'h0)
      else $error("gci command not issued");
   a_op_decode: assert property (fire && cmd_q.opcode == 2'h1 &&
      !cmd_q.gci_select && cmd_q.target_channel_field == 2'h1 |=>
      CMD_OP == 4'h2 && CMD_CHAN == 3'h2)
      else $error("opcode or channel decoded wrong");
   a_rsvd_chan: assert property (fire && !cmd_q.gci_select &&
      cmd_q.target_channel_field == 2'h3 |=> !CMD_VALID)
      else $error("reserved channel command issued");
   a_force_low: assert property (mode_q.force_low_bit && gci_md |=>
      !L1_TXD)
      else $error("layer one tx data not forced low");
   a_strobe_swap: assert property (B1_SLOT && !B2_SLOT &&
      mode_q.strobe_control_one |=> DS2 && !DS1)
      else $error("strobe swap wrong for b1");
   a_wired_or: assert property (channel_clock_config_q[0].wired_or_select |=>
      !TXD_O[0] && TXD_OE[0] == !$past(CH_TXD[0]))
      else $error("open drain drive wrong");
   a_tx_clk_pin: assert property (channel_clock_config_q[1].tx_clock_select |=>
      TX_CLK_EN[1] == $past(rise[2]))
      else $error("tx clock not from pin");
   a_flag_share: assert property (scm_q[0].flag_sharing_enable &&
      scm_q[0].flag_count_field == 4'h5 |=> CHAN_CFG[0].min_flags == 4'h4)
      else $error("shared flag count not reduced");
endmodule : sccr_regs

//--- sccr_far_end.sv
// sccr_far_end.sv: pins and channel engine stand-in beside sccr_regs
// assumes the shared CLK; pin clocks are divided from it
`timescale 1ns/10ps
module sccr_far_end (
   input wire logic CLK,
   input wire logic RUN,
   input wire logic DATA,
   output logic TIMER_INPUT_ONE_PIN,
   output logic [2:0] TX_CLOCK_PIN,
   output logic [2:0] RCLK,
   output logic L1_TXD_IN,
   output logic [2:0] CH_TXD,
   output logic B1_SLOT,
   output logic B2_SLOT,
   output logic [2:0] SLOT_BIT
);
   logic [3:0] cnt_q = 4'h0;
   always_ff @(posedge CLK) begin
      cnt_q <= cnt_q + 4'h1;
   end
   // pin clocks stand low while stopped, never mid-level
   assign TIMER_INPUT_ONE_PIN = RUN & cnt_q[1];
   assign TX_CLOCK_PIN = {3{RUN & cnt_q[2]}};
   assign RCLK = {3{RUN & cnt_q[3]}};
   assign L1_TXD_IN = DATA;
   assign CH_TXD = {3{DATA}};
   // frame of 16 bits: b1 bits 0..7 then b2 bits 0..7
   assign B1_SLOT = ~cnt_q[3];
   assign B2_SLOT = cnt_q[3];
   assign SLOT_BIT = cnt_q[2:0];
endmodule : sccr_far_end

//--- tb_serial_channel_config_regs.sv
// tb_serial_channel_config_regs.sv: self-checking bench for sccr_regs
// assumes sccr_far_end drives the pins; APB tasks act as host software
`timescale 1ns/10ps
module tb_serial_channel_config_regs
   import sccr_pkg::*;
;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [15:0] PADDR = 16'h0000;
   logic [31:0] PWDATA = 32'h0;
   logic RUN = 1'b1;
   logic DATA = 1'b0;
   logic [31:0] PRDATA, rdat;
   logic PREADY, PSLVERR, rerr, TIMER_INPUT_ONE_PIN, L1_TXD_IN, L1_TXD;
   logic B1_SLOT, B2_SLOT, DS1, DS2, SLOT_BIT_EN, CMD_VALID, CMD_GCI;
   logic [2:0] TX_CLOCK_PIN, RCLK, CH_TXD, TXD_O, TXD_OE, SLOT_BIT;
   logic [2:0] TX_CLK_EN, RX_CLK_EN, CMD_CHAN;
   logic [3:0] CMD_OP;
   sccr_chan_cfg_t [2:0] CHAN_CFG;
   sccr_si_cfg_t SI_CFG;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   int cnt [5];
   localparam logic [15:0] ADR [9] = '{16'h2180, 16'h2208, 16'h2248,
      16'h2288, 16'h2210, 16'h2250, 16'h2290, 16'h22c8, 16'h22d0};
   // command byte, then expected valid, op, channel, gci
   localparam logic [16:0] CMDS [7] = '{
      {8'h01, 1'h1, 4'h1, 3'h1, 1'h0}, {8'h13, 1'h1, 4'h2, 3'h2, 1'h0},
      {8'h25, 1'h1, 4'h4, 3'h4, 1'h0}, {8'h31, 1'h1, 4'h0, 3'h1, 1'h0},
      {8'h07, 1'h0, 4'h0, 3'h0, 1'h0}, {8'h55, 1'h1, 4'h2, 3'h0, 1'h1},
      {8'h33, 1'h1, 4'h8, 3'h2, 1'h0}};
   // pin clocks running, config word, expected tx enables in 80 cycles
   localparam logic [24:0] CLKS [5] = '{{1'h1, 16'h1008, 8'h10},
      {1'h1, 16'h1009, 8'h04}, {1'h1, 16'h4002, 8'h0a},
      {1'h1, 16'h2000, 8'h0a}, {1'h0, 16'h2000, 8'h00}};

   sccr_regs i_dut (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
      .PWDATA, .PRDATA, .PREADY, .PSLVERR, .TIMER_INPUT_ONE_PIN, .TX_CLOCK_PIN, .RCLK,
      .L1_TXD_IN, .L1_TXD, .CH_TXD, .TXD_O, .TXD_OE, .B1_SLOT, .B2_SLOT,
      .SLOT_BIT, .DS1, .DS2, .SLOT_BIT_EN, .TX_CLK_EN, .RX_CLK_EN,
      .CMD_VALID, .CMD_OP, .CMD_CHAN, .CMD_GCI, .CHAN_CFG, .SI_CFG);
   sccr_far_end i_far (.CLK, .RUN, .DATA, .TIMER_INPUT_ONE_PIN, .TX_CLOCK_PIN, .RCLK,
      .L1_TXD_IN, .CH_TXD, .B1_SLOT, .B2_SLOT, .SLOT_BIT);

   initial begin
      forever #5 CLK = ~CLK;
   end

   task automatic close_out();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   always @(posedge CLK) begin
      cyc++;
      if (cyc == 8000) begin
         miscompares++;
         $display("Error at %0t: run did not finish", $time);
         close_out();
      end
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic near(input int got, input int exp);
      chk(got >= exp - 1 && got <= exp + 1, 1);
   endtask : near

   // held until pready is seen high, then released, with one idle edge before return
   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask : apb

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0000, d});
   endtask : wr

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk({rerr, rdat}, {1'b0, e});
   endtask : rd_chk

   task automatic cmd(input logic [16:0] t);
      int n;
      n = 0;
      wr(ADR[0], {8'h00, t[16:9]});
      rd_chk(ADR[0], {24'h0, t[16:9]});
      while (CMD_VALID !== 1'b1 && n < 20) begin
         @(posedge CLK);
         n++;
      end
      chk({CMD_VALID, CMD_OP, CMD_CHAN, CMD_GCI}, t[8:0]);
      rd_chk(ADR[0], {24'h0, t[16:10], 1'b0});
   endtask : cmd

   task automatic count(input int n);
      cnt = '{default: 0};
      repeat (4) @(posedge CLK);
      repeat (n) begin
         @(posedge CLK);
         cnt[0] += DS1;
         cnt[1] += DS2;
         cnt[2] += SLOT_BIT_EN;
         cnt[3] += TX_CLK_EN[0];
         cnt[4] += RX_CLK_EN[0];
      end
   endtask : count

   task automatic pin(input logic d, input logic [6:0] e);
      DATA <= d;
      repeat (4) @(posedge CLK);
      chk({L1_TXD, TXD_O, TXD_OE}, e);
   endtask : pin

   initial begin
      repeat (12) @(posedge CLK);
      SRST <= 1'b0;
      @(posedge CLK);
      for (int i = 0; i < 9; i++) begin
         rd_chk(ADR[i], 32'h0);
      end
      wr(ADR[5], 16'h0003);
      for (int i = 0; i < 7; i++) begin
         cmd(CMDS[i]);
      end
      wr(ADR[4], 16'h5dd8);
      count(1);
      chk(CHAN_CFG[0], {2'h1, 5'h1e, 4'h4, 4'h4});
      wr(ADR[4], 16'h5004);
      count(1);
      chk(CHAN_CFG[0], {2'h2, 5'h00, 4'h5, 4'h0});
      wr(ADR[8], 16'h6396);
      wr(ADR[7], 16'h0103);
      count(32);
      chk(SI_CFG, {5'h1a, 3'h5, 3'h1, 3'h0, 3'h4});
      chk(cnt[0], 16);
      chk(cnt[1], 16);
      chk(cnt[2], 6);
      wr(ADR[8], 16'h6796);
      count(32);
      chk(cnt[0], 0);
      chk(cnt[1], 32);
      wr(ADR[8], 16'h6794);
      count(32);
      chk(cnt[2], 0);
      apb(1'b0, 16'h2184, 32'h0);
      chk({rerr, rdat}, {1'b1, 32'h0});
      apb(1'b1, 16'h220a, 32'hffff);
      chk(rerr, 1);
      rd_chk(ADR[1], 32'h0);
      for (int i = 0; i < 5; i++) begin
         RUN <= CLKS[i][24];
         wr(ADR[1], CLKS[i][23:8]);
         count(80);
         near(cnt[3], int'(CLKS[i][7:0]));
         if (i == 0) near(cnt[4], 5);
      end
      wr(ADR[2], 16'h0000);
      wr(ADR[3], 16'h8000);
      wr(ADR[8], 16'h8003);
      pin(1'b1, 7'h1b);
      pin(1'b0, 7'h07);
      wr(ADR[8], 16'h8000);
      pin(1'b1, 7'h5b);
      wr(ADR[0], 16'h0008);
      rd_chk(ADR[0], 32'h0);
      for (int i = 1; i < 9; i++) begin
         wr(ADR[i], 16'hffff);
         rd_chk(ADR[i], (i > 3 && i < 7) ? 32'hfdff : 32'hffff);
      end
      close_out();
   end
endmodule : tb_serial_channel_config_regs
